// >>> hdl/cpuacc_top.v
// Purpose: Main operand, auxiliary operand and status flag registers of the CPU.
// Assumes: One clock, asynchronous active-low reset, AXI4-Lite register access.
// Notes:   The CPU core drives alu_op_i; software writes come over the bus.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`default_nettype none
`include "cpuacc_regs.vh"

module cpuacc_top #(
  parameter ADDR_W = 8
) (
  input  wire              ref_clk_i,
  input  wire              nrst_i,
  input  wire [2:0]        alu_op_i,
  input  wire [7:0]        alu_operand_i,
  input  wire              mul_load_i,
  input  wire [7:0]        mul_aux_i,
  input  wire [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire              s_axi_awvalid_i,
  output reg               s_axi_awready_o,
  input  wire [31:0]       s_axi_wdata_i,
  input  wire [3:0]        s_axi_wstrb_i,
  input  wire              s_axi_wvalid_i,
  output reg               s_axi_wready_o,
  output reg  [1:0]        s_axi_bresp_o,
  output reg               s_axi_bvalid_o,
  input  wire              s_axi_bready_i,
  input  wire [ADDR_W-1:0] s_axi_araddr_i,
  input  wire              s_axi_arvalid_i,
  output reg               s_axi_arready_o,
  output reg  [31:0]       s_axi_rdata_o,
  output reg  [1:0]        s_axi_rresp_o,
  output reg               s_axi_rvalid_o,
  input  wire              s_axi_rready_i,
  output reg  [7:0]        main_operand_o,
  output reg  [7:0]        aux_operand_o,
  output reg  [7:0]        status_flags_o,
  output reg  [4:0]        bank_base_o,
  output reg  [15:0]       fetch_addr_o
);

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  reg  [7:0]        main_operand_register;
  reg  [7:0]        aux_operand_register;
  reg               carry_flag;
  reg               half_carry_flag;
  reg               user_flag_zero;
  reg  [1:0]        bank_select_field;
  reg               signed_wrap_flag;
  reg               user_flag_one;
  reg               boot_done;
  reg  [ADDR_W-1:0] aw_addr;
  reg               aw_held;
  reg  [31:0]       w_data;
  reg  [3:0]        w_strb;
  reg               w_held;

  wire [7:0] alu_result;
  wire       alu_carry;
  wire       alu_half;
  wire       alu_wrap;
  wire       alu_write;
  wire       parity_now;
  wire [7:0] status_now;
  wire       do_write;
  wire [ADDR_W-1:0] wr_addr;
  wire [31:0]       wr_data;
  wire              wr_lane0;

  // Returns one when the byte address names a mapped register.
  function mapped;
    input [ADDR_W-1:0] addr;
    begin
      mapped = (addr == `CPUACC_ADDR_STATUS) || (addr == `CPUACC_ADDR_MAIN) ||
               (addr == `CPUACC_ADDR_AUX) || (addr == `CPUACC_ADDR_CTRL) ||
               (addr == `CPUACC_ADDR_INFO);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Arithmetic unit
  // --------------------------------------------------------------------------
  cpuacc_alu cpuacc_alu_inst (
    .op_i     (alu_op_i),
    .a_i      (main_operand_register),
    .b_i      (alu_operand_i),
    .carry_i  (carry_flag),
    .result_o (alu_result),
    .carry_o  (alu_carry),
    .half_o   (alu_half),
    .wrap_o   (alu_wrap),
    .write_o  (alu_write)
  );

  // Parity is pure logic on the stored operand, so no write can make it stale.
  assign parity_now = ^main_operand_register;
  assign status_now = {carry_flag, half_carry_flag, user_flag_zero,
                       bank_select_field, signed_wrap_flag, user_flag_one,
                       parity_now};

  // --------------------------------------------------------------------------
  // AXI4-Lite write path
  // --------------------------------------------------------------------------
  // Address and data may arrive in either order; whichever is taken first is latched until the other arrives.
  assign wr_addr  = aw_held ? aw_addr : s_axi_awaddr_i;
  assign wr_data  = w_held ? w_data : s_axi_wdata_i;
  assign wr_lane0 = w_held ? w_strb[0] : s_axi_wstrb_i[0];
  assign do_write = (aw_held || (s_axi_awvalid_i && s_axi_awready_o)) &&
                    (w_held || (s_axi_wvalid_i && s_axi_wready_o)) &&
                    !s_axi_bvalid_o;

  // Channel handshakes; ready drops while a part is held or a response waits.
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_held         <= 1'b0;
      aw_addr         <= {ADDR_W{1'b0}};
      w_held          <= 1'b0;
      w_data          <= 32'h00000000;
      w_strb          <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `CPUACC_RESP_OKAY;
    end else begin
      if (do_write) begin
        aw_held         <= 1'b0;
        w_held          <= 1'b0;
        s_axi_awready_o <= 1'b0;
        s_axi_wready_o  <= 1'b0;
        s_axi_bvalid_o  <= 1'b1;
        s_axi_bresp_o   <= mapped(wr_addr) ? `CPUACC_RESP_OKAY : `CPUACC_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid_i && s_axi_awready_o) begin
          aw_held         <= 1'b1;
          aw_addr         <= s_axi_awaddr_i;
          s_axi_awready_o <= 1'b0;
        end else if (!aw_held && !s_axi_bvalid_o) begin
          s_axi_awready_o <= 1'b1;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
          w_held         <= 1'b1;
          w_data         <= s_axi_wdata_i;
          w_strb         <= s_axi_wstrb_i;
          s_axi_wready_o <= 1'b0;
        end else if (!w_held && !s_axi_bvalid_o) begin
          s_axi_wready_o <= 1'b1;
        end
        if (s_axi_bvalid_o && s_axi_bready_i) begin
          s_axi_bvalid_o <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Operand and status registers
  // --------------------------------------------------------------------------
  // A bus write in the same cycle as an ALU result loses to the ALU in the carry flag and in each field the op updates, since
  // the instruction stream owns these registers; software retries if needed.
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      main_operand_register <= `CPUACC_RST_BYTE;
      aux_operand_register  <= `CPUACC_RST_BYTE;
      carry_flag            <= 1'b0;
      half_carry_flag       <= 1'b0;
      user_flag_zero        <= 1'b0;
      bank_select_field     <= 2'b00;
      signed_wrap_flag      <= 1'b0;
      user_flag_one         <= 1'b0;
    end else begin
      if (do_write && wr_lane0 && (wr_addr == `CPUACC_ADDR_MAIN)) begin
        main_operand_register <= wr_data[7:0];
      end
      if (mul_load_i) begin
        aux_operand_register <= mul_aux_i;
      end else if (do_write && wr_lane0 && (wr_addr == `CPUACC_ADDR_AUX)) begin
        aux_operand_register <= wr_data[7:0];
      end
      if (do_write && wr_lane0 && (wr_addr == `CPUACC_ADDR_STATUS)) begin
        carry_flag        <= wr_data[`CPUACC_BIT_CARRY];
        half_carry_flag   <= wr_data[`CPUACC_BIT_HALF];
        user_flag_zero    <= wr_data[`CPUACC_BIT_USER0];
        bank_select_field <= wr_data[`CPUACC_BIT_BANK_HI:`CPUACC_BIT_BANK_LO];
        signed_wrap_flag  <= wr_data[`CPUACC_BIT_WRAP];
        user_flag_one     <= wr_data[`CPUACC_BIT_USER1];
      end
      if (alu_op_i != `CPUACC_OP_NONE) begin
        carry_flag <= alu_carry;
        if (alu_op_i != `CPUACC_OP_RLC && alu_op_i != `CPUACC_OP_RRC &&
            alu_op_i != `CPUACC_OP_INC) begin
          half_carry_flag  <= alu_half;
          signed_wrap_flag <= alu_wrap;
        end
        if (alu_write) begin
          main_operand_register <= alu_result;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read path
  // --------------------------------------------------------------------------
  // One read at a time; arready drops while the data beat waits.
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h00000000;
      s_axi_rresp_o   <= `CPUACC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rresp_o   <= mapped(s_axi_araddr_i) ? `CPUACC_RESP_OKAY :
                                                     `CPUACC_RESP_SLVERR;
        case (s_axi_araddr_i)
          `CPUACC_ADDR_STATUS: s_axi_rdata_o <= {24'h000000, status_now};
          `CPUACC_ADDR_MAIN:   s_axi_rdata_o <= {24'h000000, main_operand_register};
          `CPUACC_ADDR_AUX:    s_axi_rdata_o <= {24'h000000, aux_operand_register};
          `CPUACC_ADDR_CTRL:   s_axi_rdata_o <= {27'h0, bank_base_o};
          `CPUACC_ADDR_INFO:   s_axi_rdata_o <= {16'h0000, fetch_addr_o};
          default:             s_axi_rdata_o <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o  <= 1'b0;
      end else if (!s_axi_rvalid_o) begin
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Mirrored outputs
  // --------------------------------------------------------------------------
  // Operand, status and bank outputs are registered copies, one cycle behind the registers; fetch_addr_o only holds the reset value.
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      main_operand_o <= `CPUACC_RST_BYTE;
      aux_operand_o  <= `CPUACC_RST_BYTE;
      status_flags_o <= `CPUACC_RST_BYTE;
      bank_base_o    <= 5'h00;
      fetch_addr_o   <= `CPUACC_RST_PC;
      boot_done      <= 1'b0;
    end else begin
      main_operand_o <= main_operand_register;
      aux_operand_o  <= aux_operand_register;
      status_flags_o <= status_now;
      bank_base_o    <= {bank_select_field, 3'b000};
      boot_done      <= 1'b1;
      if (!boot_done) begin
        fetch_addr_o <= `CPUACC_RST_PC;
      end
    end
  end

endmodule
`default_nettype wire

// >>> hdl/cpuacc_regs.vh
// Purpose: Constants for the CPU working register block.
// Assumes: Registers sit on a 32-bit AXI4-Lite bus, one aligned word each.
// Notes:   Printed offsets are multiples of four and are used as byte addresses.
// Function
// - Eight-bit main operand register, resets to zero.
// - ALU results update matching status flag bits.
// - Eight-bit auxiliary operand register, resets to zero.
// - Carry flag follows carry, borrow, rotate, compare.
// - Half carry follows carry out of bit three.
// - Two user flags, software only, reset zero.
// - Bank select picks working registers 8n to 8n+7.
// - Signed wrap flag follows arithmetic overflow.
// - Parity bit shows odd count of ones.
// - Reset clears registers, fetch starts at zero.
`ifndef CPUACC_REGS_VH
`define CPUACC_REGS_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define CPUACC_ADDR_STATUS   8'hd0
`define CPUACC_ADDR_MAIN     8'he0
`define CPUACC_ADDR_AUX      8'hf0
`define CPUACC_ADDR_CTRL     8'hf8
`define CPUACC_ADDR_INFO     8'hfc

// ----------------------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------------------
`define CPUACC_BIT_CARRY     7
`define CPUACC_BIT_HALF      6
`define CPUACC_BIT_USER0     5
`define CPUACC_BIT_BANK_HI   4
`define CPUACC_BIT_BANK_LO   3
`define CPUACC_BIT_WRAP      2
`define CPUACC_BIT_USER1     1
`define CPUACC_BIT_PARITY    0
`define CPUACC_SW_MASK       8'hfe

// ----------------------------------------------------------------------------
// Reset values and operation codes
// ----------------------------------------------------------------------------
`define CPUACC_RST_BYTE      8'h00
`define CPUACC_RST_PC        16'h0000
`define CPUACC_OP_NONE       3'h0
`define CPUACC_OP_ADD        3'h1
`define CPUACC_OP_ADDC       3'h2
`define CPUACC_OP_SUBB       3'h3
`define CPUACC_OP_RLC        3'h4
`define CPUACC_OP_RRC        3'h5
`define CPUACC_OP_CMP        3'h6
`define CPUACC_OP_INC        3'h7
`define CPUACC_RESP_OKAY     2'h0
`define CPUACC_RESP_SLVERR   2'h2

`endif

// >>> hdl/cpuacc_alu.v
// Purpose: Combinational arithmetic unit for the main operand register.
// Assumes: Operands are eight bits wide; flags come out with the result.
// Notes:   No state; the top module decides when a result is written back.
`default_nettype none
`include "cpuacc_regs.vh"

module cpuacc_alu (
  input  wire [2:0] op_i,
  input  wire [7:0] a_i,
  input  wire [7:0] b_i,
  input  wire       carry_i,
  output reg  [7:0] result_o,
  output reg        carry_o,
  output reg        half_o,
  output reg        wrap_o,
  output reg        write_o
);

  reg [8:0] sum;
  reg [4:0] low;
  reg       cin;
  reg [7:0] addend;

  // Addition and subtraction share one adder; subtraction adds the complement
  // so the adder carry means "no borrow", which is what the carry flag shows.
  always @* begin
    sum      = 9'h000;
    low      = 5'h00;
    cin      = 1'b0;
    addend   = b_i;
    result_o = a_i;
    carry_o  = carry_i;
    half_o   = 1'b0;
    wrap_o   = 1'b0;
    write_o  = 1'b0;
    case (op_i)
      `CPUACC_OP_ADD, `CPUACC_OP_ADDC, `CPUACC_OP_SUBB, `CPUACC_OP_CMP: begin
        cin = (op_i == `CPUACC_OP_ADD) ? 1'b0 :
              (op_i == `CPUACC_OP_ADDC) ? carry_i :
              (op_i == `CPUACC_OP_CMP) ? 1'b1 : carry_i;
        if (op_i == `CPUACC_OP_SUBB || op_i == `CPUACC_OP_CMP) begin
          addend = ~b_i;
        end
        sum      = {1'b0, a_i} + {1'b0, addend} + {8'h00, cin};
        low      = {1'b0, a_i[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
        result_o = sum[7:0];
        carry_o  = sum[8];
        half_o   = low[4];
        wrap_o   = (a_i[7] == addend[7]) && (sum[7] != a_i[7]);
        write_o  = (op_i != `CPUACC_OP_CMP);
      end
      `CPUACC_OP_RLC: begin
        result_o = {a_i[6:0], carry_i};
        carry_o  = a_i[7];
        write_o  = 1'b1;
      end
      `CPUACC_OP_RRC: begin
        result_o = {carry_i, a_i[7:1]};
        carry_o  = a_i[0];
        write_o  = 1'b1;
      end
      `CPUACC_OP_INC: begin
        result_o = a_i + 8'h01;
        write_o  = 1'b1;
      end
      default: begin
        write_o = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// >>> bench/cpuacc_chk.sv
// Purpose: Port-level checks for the CPU working register block.
// Assumes: Register outputs lag the internal registers by one cycle.
// Notes:   Bound into every instance of the top module at the foot of this file.
`default_nettype none
`include "cpuacc_regs.vh"

module cpuacc_chk (
  input wire logic        ref_clk_i,
  input wire logic        nrst_i,
  input wire logic [2:0]  alu_op_i,
  input wire logic [7:0]  alu_operand_i,
  input wire logic        mul_load_i,
  input wire logic [7:0]  mul_aux_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [7:0]  main_operand_o,
  input wire logic [7:0]  aux_operand_o,
  input wire logic [7:0]  status_flags_o,
  input wire logic [4:0]  bank_base_o,
  input wire logic [15:0] fetch_addr_o
);
  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  // An op sampled at one edge is visible on the outputs two edges later.
  default clocking dc @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  a_reset_clear: assert property (disable iff (1'b0)
    !nrst_i |-> {main_operand_o, aux_operand_o, status_flags_o, fetch_addr_o} == 40'h0)
    else $error("registers not clear during reset");
  a_parity_track: assert property (status_flags_o[0] == ^main_operand_o)
    else $error("parity flag does not follow the operand");
  a_bank_map: assert property (bank_base_o == {status_flags_o[4:3], 3'h0})
    else $error("bank base does not match the bank field");
  a_fetch_home: assert property (fetch_addr_o == 16'h0000)
    else $error("fetch address left zero");
  a_add_sum: assert property (alu_op_i == `CPUACC_OP_ADD |-> ##2
    {status_flags_o[7], main_operand_o} ==
    {1'b0, $past(main_operand_o)} + $past(alu_operand_i, 2))
    else $error("add result or carry wrong");
  a_half_add: assert property (alu_op_i == `CPUACC_OP_ADD |-> ##2
    status_flags_o[6] == |(($past(main_operand_o) ^ $past(alu_operand_i, 2) ^
    main_operand_o) & 8'h10))
    else $error("half carry wrong after add");
  a_wrap_add: assert property (alu_op_i == `CPUACC_OP_ADD |-> ##2 status_flags_o[2] ==
    (|(($past(main_operand_o) ^ $past(alu_operand_i, 2) ^ main_operand_o) & 8'h80) ^
    status_flags_o[7]))
    else $error("signed wrap wrong after add");
  a_aux_load: assert property (mul_load_i |-> ##2 aux_operand_o == $past(mul_aux_i, 2))
    else $error("aux register missed the multiply load");
  a_user_keep: assert property (alu_op_i != `CPUACC_OP_NONE && !s_axi_awvalid_i &&
    !s_axi_wvalid_i |-> ##2 (status_flags_o & 8'h3a) == ($past(status_flags_o) & 8'h3a))
    else $error("ALU op altered user flags or bank field");
  a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped before it was taken");
  a_write_turn: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
    s_axi_wready_o |=> s_axi_bvalid_o && !s_axi_awready_o && !s_axi_wready_o)
    else $error("write response late or readies left high");

  c_add: cover property (alu_op_i == `CPUACC_OP_ADD);
  c_mul: cover property (mul_load_i);
  c_stall: cover property (s_axi_rvalid_o && !s_axi_rready_i);
endmodule

bind cpuacc_top cpuacc_chk cpuacc_chk_inst (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .alu_op_i(alu_op_i), .alu_operand_i(alu_operand_i),
  .mul_load_i(mul_load_i), .mul_aux_i(mul_aux_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .s_axi_rdata_o(s_axi_rdata_o), .main_operand_o(main_operand_o),
  .aux_operand_o(aux_operand_o), .status_flags_o(status_flags_o),
  .bank_base_o(bank_base_o), .fetch_addr_o(fetch_addr_o));
`default_nettype wire

// >>> bench/cpuacc_tb_top.sv
// Purpose: Self-checking bench for the CPU working register block.
// Assumes: AXI4-Lite master tasks; ALU ops are driven for one cycle.
// Notes:   Flags whose subtract meaning is open are masked out of compares.
`default_nettype none
`include "cpuacc_regs.vh"

module cpuacc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i, nrst_i, mul_load_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic        s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o;
  logic        s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rs;
  logic [2:0]  alu_op_i;
  logic [3:0]  s_axi_wstrb_i;
  logic [4:0]  bank_base_o;
  logic [7:0]  alu_operand_i, mul_aux_i, s_axi_awaddr_i, s_axi_araddr_i, mk;
  logic [7:0]  main_operand_o, aux_operand_o, status_flags_o;
  logic [15:0] fetch_addr_o, ex;
  logic [23:0] cs;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd;
  int          err_total, checked;
  // Each entry is {op, carry in, operand a, operand b}.
  localparam logic [23:0] CASES [10] = '{24'h107f01, 24'h10ff01, 24'h210f00, 24'h300001,
    24'h318001, 24'h408055, 24'h510100, 24'h601010, 24'h610f10, 24'h70ff00};
  localparam logic [7:0] PVALS [6] = '{8'h00, 8'h01, 8'h5a, 8'h80, 8'hff, 8'h7f};
  localparam logic [7:0] REGS [5] = '{`CPUACC_ADDR_STATUS, `CPUACC_ADDR_MAIN, `CPUACC_ADDR_AUX,
    `CPUACC_ADDR_CTRL, `CPUACC_ADDR_INFO};

  cpuacc_top #(.ADDR_W(8)) cpuacc_top_inst (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .alu_op_i(alu_op_i), .alu_operand_i(alu_operand_i),
    .mul_load_i(mul_load_i), .mul_aux_i(mul_aux_i), .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wdata_i(s_axi_wdata_i), .s_axi_wstrb_i(s_axi_wstrb_i),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
    .main_operand_o(main_operand_o), .aux_operand_o(aux_operand_o),
    .status_flags_o(status_flags_o), .bank_base_o(bank_base_o), .fetch_addr_o(fetch_addr_o));

  // ---------------------------------------------------------------------------
  // Clock, compare and bus tasks
  // ---------------------------------------------------------------------------
  // Free-running 100 MHz clock.
  always #5 ref_clk_i = ~ref_clk_i;

  task automatic tally_and_finish();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Every wait is bounded so that a stuck handshake ends the run as failed.
  task automatic bound(inout int n);
    n++;
    if (n > 40) begin
      err_total++;
      tally_and_finish();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int   n;
    logic pa, pw;
    n = 0;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr_i <= a;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wdata_i <= d;
    s_axi_wvalid_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      bound(n);
      if (pa && s_axi_awready_o === 1'b1) begin
        pa = 1'b0;
        s_axi_awvalid_i <= 1'b0;
      end
      if (pw && s_axi_wready_o === 1'b1) begin
        pw = 1'b0;
        s_axi_wvalid_i <= 1'b0;
      end
    end while (pa || pw);
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      bound(n);
    end while (s_axi_bvalid_o !== 1'b1);
    s_axi_bready_i <= 1'b0;
    chk(s_axi_bresp_o, er);
  endtask

  // Ready is held back one cycle so the slave must keep its answer standing.
  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      bound(n);
    end while (s_axi_arready_o !== 1'b1);
    s_axi_arvalid_i <= 1'b0;
    @(posedge ref_clk_i);
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      bound(n);
    end while (s_axi_rvalid_o !== 1'b1);
    s_axi_rready_i <= 1'b0;
    rd = s_axi_rdata_o;
    rs = s_axi_rresp_o;
  endtask

  task automatic do_reset();
    nrst_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
  endtask

  task automatic check_clear();
    foreach (REGS[i]) begin
      axi_rd(REGS[i]);
      chk(rd, 32'h0);
    end
    chk(fetch_addr_o, 32'h0);
  endtask

  // Reference result {status, operand}; subtract counts carry set as no borrow.
  function automatic logic [15:0] ref_alu(input logic [2:0] op, input logic [7:0] a,
                                          input logic [7:0] b, input logic [7:0] s);
    logic [8:0] t;
    logic [4:0] hn;
    logic [7:0] r;
    logic       c, h, v, k;
    r = a;
    c = s[7];
    h = s[6];
    v = s[2];
    k = (op == `CPUACC_OP_ADDC || op == `CPUACC_OP_SUBB) ? s[7] : 1'b0;
    case (op)
      `CPUACC_OP_ADD, `CPUACC_OP_ADDC: begin
        t = a + b + k;
        hn = a[3:0] + b[3:0] + k;
        r = t[7:0];
        c = t[8];
        h = hn[4];
        v = (a[7] == b[7]) && (r[7] != a[7]);
      end
      `CPUACC_OP_SUBB, `CPUACC_OP_CMP: begin
        t = a - b - (op == `CPUACC_OP_SUBB && !k);
        c = !t[8];
        v = (a[7] != b[7]) && (t[7] != a[7]);
        if (op == `CPUACC_OP_SUBB) r = t[7:0];
      end
      `CPUACC_OP_RLC: begin
        r = {a[6:0], s[7]};
        c = a[7];
      end
      `CPUACC_OP_RRC: begin
        r = {s[7], a[7:1]};
        c = a[0];
      end
      `CPUACC_OP_INC: r = a + 8'h01;
      default: ;
    endcase
    return {c, h, s[5:3], v, s[1], ^r, r};
  endfunction

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    {mul_load_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 4'h0;
    {s_axi_arvalid_i, s_axi_rready_i, alu_op_i, alu_operand_i, mul_aux_i} = 21'h0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 48'h0;
    s_axi_wstrb_i = 4'hf;
    err_total = 0;
    checked = 0;
    do_reset();
    check_clear();
    for (int n = 0; n < 4; n++) begin
      axi_wr(`CPUACC_ADDR_STATUS, 32'(n * 8), `CPUACC_RESP_OKAY);
      axi_rd(`CPUACC_ADDR_STATUS);
      chk(rd, n * 8);
      chk(bank_base_o, n * 8);
      axi_rd(`CPUACC_ADDR_CTRL);
      chk(rd, n * 8);
    end
    axi_wr(`CPUACC_ADDR_STATUS, 32'hff, `CPUACC_RESP_OKAY);
    axi_rd(`CPUACC_ADDR_STATUS);
    chk(rd, 32'hfe);
    foreach (PVALS[i]) begin
      axi_wr(`CPUACC_ADDR_MAIN, {24'hffffff, PVALS[i]}, `CPUACC_RESP_OKAY);
      axi_rd(`CPUACC_ADDR_MAIN);
      chk(rd, {24'h0, PVALS[i]});
      axi_rd(`CPUACC_ADDR_STATUS);
      chk(rd[0], ^PVALS[i]);
    end
    foreach (CASES[i]) begin
      cs = CASES[i];
      axi_wr(`CPUACC_ADDR_MAIN, {24'h0, cs[15:8]}, `CPUACC_RESP_OKAY);
      axi_wr(`CPUACC_ADDR_STATUS, {24'h0, cs[16], 7'h3b}, `CPUACC_RESP_OKAY);
      alu_op_i <= cs[22:20];
      alu_operand_i <= cs[7:0];
      @(posedge ref_clk_i);
      alu_op_i <= `CPUACC_OP_NONE;
      ex = ref_alu(cs[22:20], cs[15:8], cs[7:0], {cs[16], 7'h3a});
      mk = (cs[22:20] == `CPUACC_OP_SUBB) ? 8'hbf : (cs[22:20] == `CPUACC_OP_CMP) ? 8'hbf : 8'hff;
      axi_rd(`CPUACC_ADDR_MAIN);
      chk(rd, ex[7:0]);
      axi_rd(`CPUACC_ADDR_STATUS);
      chk(rd & mk, ex[15:8] & mk);
    end
    axi_wr(`CPUACC_ADDR_AUX, 32'ha5, `CPUACC_RESP_OKAY);
    axi_rd(`CPUACC_ADDR_AUX);
    chk(rd, 32'ha5);
    mul_load_i <= 1'b1;
    mul_aux_i <= 8'h3c;
    @(posedge ref_clk_i);
    mul_load_i <= 1'b0;
    // A write with byte lane 0 off is answered but must not store anything.
    s_axi_wstrb_i <= 4'he;
    axi_wr(`CPUACC_ADDR_AUX, 32'h11, `CPUACC_RESP_OKAY);
    s_axi_wstrb_i <= 4'hf;
    axi_rd(`CPUACC_ADDR_AUX);
    chk(rd, 32'h3c);
    chk(aux_operand_o, 32'h3c);
    axi_wr(8'h10, 32'h55, `CPUACC_RESP_SLVERR);
    axi_rd(8'h10);
    chk(rd, 32'h0);
    chk(rs, `CPUACC_RESP_SLVERR);
    do_reset();
    check_clear();
    tally_and_finish();
  end
endmodule
`default_nettype wire
